// ### hw/ccb_companion_control_bits.sv
// Purpose: Event counters, counter control and companion control byte
// Assumes: Register port driven by the serial interface logic on clock
// Notes:   rst models a main power reset; backup and nonvolatile bits survive it
`timescale 1ns/10ps
module ccb_companion_control_bits #(
    parameter int ARRAY_ADDR_W = 15
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic                    nvInit,
    input  wire logic [7:0]              regAddr,
    input  wire logic                    regWrite,
    input  wire logic [7:0]              regWdata,
    output logic      [7:0]              regRdata,
    input  wire logic                    eventInput1,
    input  wire logic                    eventInput2,
    input  wire logic [ARRAY_ADDR_W-1:0] arrayAddr,
    output logic      [1:0]              writeProtect,
    output logic                         arrayWriteBlock
);
    typedef struct packed {
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic        prevSel1;
        logic        prevSel2;
        logic [15:0] event_input_1;
        logic [15:0] event_input_2;
        logic [31:0] snap;
        logic        snapValid;
        logic        counterSnapshotReq;
        logic        counter1EdgePolarity;
        logic        counter2EdgePolarity;
        logic        counterCascade;
        logic [7:0]  companionControl;
        logic [7:0]  rdata;
        logic        wpBlock;
    } ccb_state_t;

    ccb_state_t state_reg;
    ccb_state_t state_next;

    // Protected span follows the top address bits, so it scales with ARRAY_ADDR_W
    function automatic logic wp_hit(input logic [1:0] code, input logic [ARRAY_ADDR_W-1:0] a);
        logic [1:0] top;
        top = a[ARRAY_ADDR_W-1 -: 2];
        unique case (code)
            ccb_pkg::WP_NONE:    wp_hit = 1'b0;
            ccb_pkg::WP_QUARTER: wp_hit = (top == 2'h0);
            ccb_pkg::WP_HALF:    wp_hit = ~top[1];
            ccb_pkg::WP_FULL:    wp_hit = 1'b1;
        endcase
    endfunction : wp_hit

    logic       sel1;
    logic       sel2;
    logic       edge1;
    logic       edge2;
    logic       wrHit;
    logic [1:0] wpField;

    // Polarity selects the level watched, so flipping it can itself look like an edge
    assign sel1    = state_reg.counter1EdgePolarity ? state_reg.sync1[1] : ~state_reg.sync1[1]; // R3 R4
    assign sel2    = state_reg.counter2EdgePolarity ? state_reg.sync2[1] : ~state_reg.sync2[1];
    assign edge1   = sel1 & ~state_reg.prevSel1;  // R3
    assign edge2   = sel2 & ~state_reg.prevSel2;
    assign wrHit   = regWrite;
    assign wpField = state_reg.companionControl[ccb_pkg::BIT_WP_HI:ccb_pkg::BIT_WP_LO];

    always_comb begin
        state_next          = state_reg;
        state_next.sync1    = {state_reg.sync1[0], eventInput1};
        state_next.sync2    = {state_reg.sync2[0], eventInput2};
        state_next.prevSel1 = sel1;
        state_next.prevSel2 = sel2;
        state_next.event_input_1     = state_reg.event_input_1 + 16'h0001 * {15'h0000, edge1}; // R8
        state_next.event_input_2     = state_reg.event_input_2 + {15'h0000, edge2};
        // Snapshot taken one cycle after the request, then the bit drops
        if (state_reg.counterSnapshotReq) begin
            state_next.snap               = {state_reg.event_input_2, state_reg.event_input_1}; // R1
            state_next.snapValid          = 1'b1;                             // R9
            state_next.counterSnapshotReq = 1'b0;                             // R2
        end
        if (wrHit) begin
            unique case (regAddr)
                ccb_pkg::ADDR_COMPANION_CTL: state_next.companionControl = regWdata; // R7
                ccb_pkg::ADDR_COUNTER_CTL: begin
                    state_next.counter1EdgePolarity = regWdata[ccb_pkg::BIT_C1_POL]; // R5
                    state_next.counter2EdgePolarity = regWdata[ccb_pkg::BIT_C2_POL];
                    state_next.counterCascade       = regWdata[ccb_pkg::BIT_CASCADE];
                    if (regWdata[ccb_pkg::BIT_SNAP_REQ]) begin
                        state_next.counterSnapshotReq = 1'b1; // R1
                    end
                end
                // Software preset wins over a coincident count in the written byte; the other byte still counts
                ccb_pkg::ADDR_EVENT_INPUT_1_LSB: state_next.event_input_1[7:0]  = regWdata;
                ccb_pkg::ADDR_EVENT_INPUT_1_MSB: state_next.event_input_1[15:8] = regWdata;
                ccb_pkg::ADDR_EVENT_INPUT_2_LSB: state_next.event_input_2[7:0]  = regWdata;
                ccb_pkg::ADDR_EVENT_INPUT_2_MSB: state_next.event_input_2[15:8] = regWdata;
                default: ;
            endcase
        end
        unique case (regAddr)
            ccb_pkg::ADDR_COMPANION_CTL: state_next.rdata = state_reg.companionControl;
            ccb_pkg::ADDR_COUNTER_CTL:   state_next.rdata = {4'h0, state_reg.counterSnapshotReq,
                state_reg.counterCascade, state_reg.counter2EdgePolarity, state_reg.counter1EdgePolarity};
            ccb_pkg::ADDR_EVENT_INPUT_1_LSB: state_next.rdata = state_reg.snapValid ? state_reg.snap[7:0]   : state_reg.event_input_1[7:0];  // R9
            ccb_pkg::ADDR_EVENT_INPUT_1_MSB: state_next.rdata = state_reg.snapValid ? state_reg.snap[15:8]  : state_reg.event_input_1[15:8];
            ccb_pkg::ADDR_EVENT_INPUT_2_LSB: state_next.rdata = state_reg.snapValid ? state_reg.snap[23:16] : state_reg.event_input_2[7:0];
            ccb_pkg::ADDR_EVENT_INPUT_2_MSB: state_next.rdata = state_reg.snapValid ? state_reg.snap[31:24] : state_reg.event_input_2[15:8];
            default:                state_next.rdata = ccb_pkg::RDATA_UNMAPPED;
        endcase
        state_next.wpBlock = wp_hit(wpField, arrayAddr); // R6
        // Main power reset leaves the backup and nonvolatile bits alone
        // Synchronisers and edge history keep running through reset: clearing them
        // would fake a level change and add a count once reset drops
        if (rst) begin
            state_next.snapValid          = 1'h0;
            state_next.counterSnapshotReq = 1'h0;
            state_next.rdata              = ccb_pkg::RST_RDATA;
            state_next.wpBlock            = 1'h0;
        end
        if (nvInit) begin
            state_next.event_input_1                 = ccb_pkg::RST_COUNTER;
            state_next.event_input_2                 = ccb_pkg::RST_COUNTER;
            state_next.snap                 = {2{ccb_pkg::RST_COUNTER}};
            state_next.counter1EdgePolarity = ccb_pkg::RST_POLARITY;
            state_next.counter2EdgePolarity = ccb_pkg::RST_POLARITY;
            state_next.counterCascade       = ccb_pkg::RST_CASCADE;
            state_next.companionControl     = ccb_pkg::RST_COMPANION_CTL;
        end
    end

    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    assign regRdata        = state_reg.rdata;
    assign writeProtect    = wpField;
    assign arrayWriteBlock = state_reg.wpBlock;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || nvInit);

    snap_capture_a: assert property (state_reg.counterSnapshotReq |=> // R1
        state_reg.snap == $past({state_reg.event_input_2, state_reg.event_input_1}) && state_reg.snapValid)
        else $error("snapshot does not match counters");
    snap_selfclear_a: assert property (state_reg.counterSnapshotReq && !wrHit |=> !state_reg.counterSnapshotReq) // R2
        else $error("snapshot request not cleared");
    edge_count_a: assert property (edge1 && !(wrHit && (regAddr == ccb_pkg::ADDR_EVENT_INPUT_1_LSB
        || regAddr == ccb_pkg::ADDR_EVENT_INPUT_1_MSB)) |=> state_reg.event_input_1 == $past(state_reg.event_input_1) + 16'h0001) // R3
        else $error("edge on input one not counted");
    polarity_edge_a: assert property ($changed(state_reg.counter1EdgePolarity) && $stable(state_reg.sync1[1])
        && state_reg.prevSel1 == 1'b0 |-> edge1) // R4
        else $error("polarity flip did not register as edge");
    polarity_read_a: assert property (regAddr == ccb_pkg::ADDR_COUNTER_CTL |=> // R5
        regRdata[ccb_pkg::BIT_C1_POL] == $past(state_reg.counter1EdgePolarity))
        else $error("polarity readback wrong");
    wp_full_a: assert property (wpField == ccb_pkg::WP_FULL && $stable(wpField) |=> arrayWriteBlock) // R6
        else $error("full protect not blocking");
    wp_none_a: assert property (wpField == ccb_pkg::WP_NONE |=> !arrayWriteBlock) // R6
        else $error("no protect but blocking");
    wp_hold_a: assert property (!(wrHit && regAddr == ccb_pkg::ADDR_COMPANION_CTL) |=> $stable(wpField)) // R7
        else $error("write protect field changed without write");
    msb_carry_a: assert property (edge1 && state_reg.event_input_1[7:0] == 8'hFF && !wrHit |=> // R8
        state_reg.event_input_1[15:8] == $past(state_reg.event_input_1[15:8]) + 8'h01)
        else $error("MSB missed LSB overflow");
    snap_read_a: assert property (state_reg.snapValid && regAddr == ccb_pkg::ADDR_EVENT_INPUT_1_LSB |=> // R9
        regRdata == $past(state_reg.snap[7:0]))
        else $error("counter read not from snapshot");

    // Snapshot request and hold
    req_set_a: assert property (wrHit && regAddr == ccb_pkg::ADDR_COUNTER_CTL // R1
        && regWdata[ccb_pkg::BIT_SNAP_REQ] |=> state_reg.counterSnapshotReq)
        else $error("snapshot request not taken");
    req_read_a: assert property (regAddr == ccb_pkg::ADDR_COUNTER_CTL |=> // R2
        regRdata[ccb_pkg::BIT_SNAP_REQ] == $past(state_reg.counterSnapshotReq))
        else $error("snapshot request readback wrong");
    snap_hold_a: assert property (state_reg.snapValid && !state_reg.counterSnapshotReq |=> // R9
        $stable(state_reg.snap) && state_reg.snapValid)
        else $error("snapshot changed without request");
    snap_msb_a: assert property (state_reg.snapValid && regAddr == ccb_pkg::ADDR_EVENT_INPUT_1_MSB |=> // R9
        regRdata == $past(state_reg.snap[15:8]))
        else $error("counter MSB read not from snapshot");

    // Steady pin and polarity must never count; a stale edge history would
    fall_count_a: assert property (!state_reg.counter1EdgePolarity && $stable(state_reg.counter1EdgePolarity) // R3
        && $fell(state_reg.sync1[1]) |-> edge1)
        else $error("falling edge on input one missed");
    rise_count_a: assert property (state_reg.counter1EdgePolarity && $stable(state_reg.counter1EdgePolarity) // R3
        && $rose(state_reg.sync1[1]) |-> edge1)
        else $error("rising edge on input one missed");
    quiet_hold_a: assert property ($stable(state_reg.sync1[1]) && $stable(state_reg.counter1EdgePolarity) // R3
        && !wrHit |=> $stable(state_reg.event_input_1))
        else $error("input one counted without an edge");
    lsb_only_a: assert property (edge1 && state_reg.event_input_1[7:0] != 8'hFF && !wrHit |=> // R8
        $stable(state_reg.event_input_1[15:8]))
        else $error("MSB moved without LSB overflow");
    pol_write_a: assert property (wrHit && regAddr == ccb_pkg::ADDR_COUNTER_CTL |=> // R5
        state_reg.counter1EdgePolarity == $past(regWdata[ccb_pkg::BIT_C1_POL]))
        else $error("polarity write not stored");

    // Write protect decode and storage
    wp_quarter_a: assert property (wpField == ccb_pkg::WP_QUARTER |=> // R6
        arrayWriteBlock == ($past(arrayAddr) < (1 << (ARRAY_ADDR_W - 2))))
        else $error("quarter protect decode wrong");
    wp_half_a: assert property (wpField == ccb_pkg::WP_HALF |=> // R6
        arrayWriteBlock == ($past(arrayAddr) < (1 << (ARRAY_ADDR_W - 1))))
        else $error("half protect decode wrong");
    wp_write_a: assert property (wrHit && regAddr == ccb_pkg::ADDR_COMPANION_CTL |=> // R7
        wpField == $past(regWdata[ccb_pkg::BIT_WP_HI:ccb_pkg::BIT_WP_LO]))
        else $error("write protect write not stored");

    // Reset only touches volatile state
    wp_keep_a: assert property (@(posedge clock) disable iff (nvInit) rst && !wrHit |=> $stable(writeProtect)) // R7
        else $error("write protect field lost on reset");
    reset_clear_a: assert property (@(posedge clock) disable iff (nvInit) rst |=> // R9
        !state_reg.counterSnapshotReq && !state_reg.snapValid && regRdata == ccb_pkg::RST_RDATA)
        else $error("volatile state not cleared by reset");

    snap_cov_c: cover property (wrHit && regAddr == ccb_pkg::ADDR_COUNTER_CTL
        && regWdata[ccb_pkg::BIT_SNAP_REQ] ##2 state_reg.snapValid);
    carry_cov_c: cover property (edge1 && state_reg.event_input_1[7:0] == 8'hFF);
    block_cov_c: cover property (wpField == ccb_pkg::WP_HALF && arrayWriteBlock);
    spur_cov_c: cover property ($changed(state_reg.counter1EdgePolarity) && edge1);
    quarter_cov_c: cover property (wpField == ccb_pkg::WP_QUARTER && arrayWriteBlock);
endmodule : ccb_companion_control_bits

// ### hw/ccb_pkg.sv
// Purpose: Constants for the companion control bits and event counters
// Assumes: Byte wide register port, one register per address
// Notes:   Operation list below
//
// Operation
// R1 - Snapshot request latches all four counter bytes
// R2 - Snapshot request bit clears itself
// R3 - Input one counts falling or rising edge
// R4 - Polarity change may add one count
// R5 - Counter one polarity kept on backup
// R6 - Two bit field selects protected array part
// R7 - Write protect field kept across power
// R8 - Counter one MSB increments on LSB overflow
// R9 - Counter reads return snapshot until next request
package ccb_pkg;
    localparam logic [7:0] ADDR_COMPANION_CTL = 8'h0B;
    localparam logic [7:0] ADDR_COUNTER_CTL   = 8'h0C;
    localparam logic [7:0] ADDR_EVENT_INPUT_1_LSB      = 8'h0D;
    localparam logic [7:0] ADDR_EVENT_INPUT_1_MSB      = 8'h0E;
    localparam logic [7:0] ADDR_EVENT_INPUT_2_LSB      = 8'h0F;
    localparam logic [7:0] ADDR_EVENT_INPUT_2_MSB      = 8'h10;
    // Counter control bit positions
    localparam int         BIT_C1_POL         = 0;
    localparam int         BIT_C2_POL         = 1;
    localparam int         BIT_CASCADE        = 2;
    localparam int         BIT_SNAP_REQ       = 3;
    // Companion control write protect field
    localparam int         BIT_WP_LO          = 3;
    localparam int         BIT_WP_HI          = 4;
    // Nonvolatile defaults loaded by nvInit; RST_RDATA is loaded by rst
    localparam logic [7:0] RST_COMPANION_CTL  = 8'h00;
    localparam logic       RST_POLARITY       = 1'h0;
    localparam logic [15:0] RST_COUNTER       = 16'h0000;
    localparam logic       RST_CASCADE        = 1'h0;
    localparam logic [7:0] RST_RDATA          = 8'h00;
    localparam logic [1:0] WP_NONE            = 2'h0;
    localparam logic [1:0] WP_QUARTER         = 2'h1;
    localparam logic [1:0] WP_HALF            = 2'h2;
    localparam logic [1:0] WP_FULL            = 2'h3;
    localparam logic [7:0] RDATA_UNMAPPED     = 8'h00;
endpackage : ccb_pkg

// ### sim/ccb_companion_control_bits_tb.sv
// Purpose: Self-checking bench for the companion control bits
// Assumes: Inputs change at the falling clock edge
// Notes:   Counter is rewritten after a polarity change, since that change may add a count
`timescale 1ns/10ps
module ccb_companion_control_bits_tb;
    logic        clock           = 1'b0;
    logic        rst             = 1'b1;
    logic        nvInit          = 1'b1;
    logic [7:0]  regAddr         = 8'h00;
    logic        regWrite        = 1'b0;
    logic [7:0]  regWdata        = 8'h00;
    logic [7:0]  regRdata;
    logic        eventInput1     = 1'b1;
    logic        eventInput2     = 1'b1;
    logic [14:0] arrayAddr       = 15'h0000;
    logic [1:0]  writeProtect;
    logic        arrayWriteBlock;
    int          errorCnt        = 0;
    int          checks          = 0;
    int          cycles          = 0;

    ccb_companion_control_bits DUT (.clock(clock), .rst(rst), .nvInit(nvInit), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .eventInput1(eventInput1),
        .eventInput2(eventInput2), .arrayAddr(arrayAddr), .writeProtect(writeProtect),
        .arrayWriteBlock(arrayWriteBlock));

    always #50 clock = ~clock;

    // Whole run needs about 110 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errorCnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (errorCnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
    endtask : wr

    // Read data is registered, so it is looked at one cycle after the address
    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        regAddr = a;
        @(negedge clock);
        cmp("regRdata", exp, regRdata);
    endtask : chk

    // Pin passes two sync flops before the count lands
    task automatic pin(input logic v);
        @(negedge clock);
        eventInput1 = v;
        repeat (4) @(negedge clock);
    endtask : pin

    task automatic protect_codes();
        logic [2:0] hit;
        for (int c = 0; c < 4; c++) begin
            wr(8'h0B, 8'(c << 3));
            chk(8'h0B, 8'(c << 3));
            cmp("writeProtect", 8'(c), {6'h00, writeProtect});
            hit = (c == 0) ? 3'h0 : (c == 1) ? 3'h1 : (c == 2) ? 3'h3 : 3'h7;
            for (int i = 0; i < 3; i++) begin
                arrayAddr = (i == 0) ? 15'h0000 : (i == 1) ? 15'h2000 : 15'h7FFF;
                @(negedge clock);
                cmp("arrayWriteBlock", {7'h00, hit[i]}, {7'h00, arrayWriteBlock});
            end
        end
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        cmp("writeProtect", 8'h03, {6'h00, writeProtect});
        chk(8'h0B, 8'h18);
    endtask : protect_codes

    task automatic edge_count();
        wr(8'h0C, 8'h00);
        wr(8'h0D, 8'hFF);
        wr(8'h0E, 8'h00);
        pin(1'b0);
        chk(8'h0D, 8'h00);
        chk(8'h0E, 8'h01);
        pin(1'b1);
        chk(8'h0D, 8'h00);
        wr(8'h0C, 8'h01);
        chk(8'h0D, 8'h01);
        chk(8'h0C, 8'h01);
        wr(8'h0D, 8'h10);
        pin(1'b0);
        chk(8'h0D, 8'h10);
        pin(1'b1);
        chk(8'h0D, 8'h11);
    endtask : edge_count

    task automatic snapshot();
        wr(8'h0F, 8'h5A);
        wr(8'h0C, 8'h09);
        repeat (2) @(negedge clock);
        chk(8'h0C, 8'h01);
        pin(1'b0);
        pin(1'b1);
        chk(8'h0D, 8'h11);
        chk(8'h0F, 8'h5A);
        wr(8'h0C, 8'h09);
        repeat (2) @(negedge clock);
        chk(8'h0D, 8'h12);
        chk(8'h20, 8'h00);
    endtask : snapshot

    initial begin
        repeat (3) @(negedge clock);
        rst = 1'b0;
        nvInit = 1'b0;
        protect_codes();
        edge_count();
        snapshot();
        print_verdict();
    end
endmodule : ccb_companion_control_bits_tb
